// ===== hdl/frs_pkg.sv
// Constants and state codes for the flash reset sequencer
// Operation
// - Hardware reset arriving during software reset may be ignored.
// - Power-on reset runs for power-up delay; host keeps select high.
// - Reset inputs ignored in power-on; held low extends reset plus hold time.
// - Shared line acts as reset after guard time or quad/FOUR_WIRE_COMMAND_MODE disabled.
// - Low longer than pulse width restores registers; recovery period follows.
// - Within guard time shared pin reset is ignored; select low means data.
// - Failed power-on makes next reset a full power-on process.
// - Arm then execute software reset works whenever reset pins are high; the code accepts it only in FRS_READY.
// - Clearing nonvolatile enable makes shared pin purely data line 3.
// - Shared-pin reset aborts work, tristates outputs, rejects commands, standby.
// - After quad data to host, device drives line 3 high during guard.
// - Reset held at power-up end keeps device reset; select waits hold time.
// - Shared reset active on volatile enable bit; quad active on quad bit.
package frs_pkg;
	localparam int CLK_PERIOD_NS        = 10;
	localparam int POWER_UP_DELAY_US    = 300;
	localparam int RECOVERY_PERIOD_US   = 100;
	localparam int PULSE_WIDTH_NS       = 200;
	localparam int HOLD_TIME_NS         = 150;
	localparam int SETUP_TIME_NS        = 50;
	localparam int GUARD_TIME_NS        = 50;
	localparam int SOFT_RESET_NS        = 1000;
	localparam int POWER_UP_CYC  = POWER_UP_DELAY_US * 1000 / CLK_PERIOD_NS;
	localparam int RECOVERY_CYC  = RECOVERY_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int PULSE_CYC     =
		(PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC      =
		(HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC     =
		(SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GUARD_CYC     =
		(GUARD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SOFT_CYC      =
		(SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 24;
	localparam logic [7:0] CMD_SOFT_ARM  = 8'h66;
	localparam logic [7:0] CMD_SOFT_EXEC = 8'h99;

	typedef enum logic [5:0] {
		FRS_POWER_UP = 6'h01,
		FRS_READY    = 6'h02,
		FRS_RECOVER  = 6'h04,
		FRS_HOLD     = 6'h08,
		FRS_SOFT     = 6'h10,
		FRS_SETUP    = 6'h20
	} frs_state_t;
endpackage

// ===== hdl/frs_low_timer.sv
// Low-level persistence counter used to qualify reset pulses
`timescale 1ns/10ps
module frs_low_timer #(
	parameter int LIMIT = 20
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic arst_n,
	// Level to qualify
	input  wire logic active,
	output logic      qualified
);
	logic [15:0] cnt_reg;

	// Saturating count; qualified once the level outlasts LIMIT cycles
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_reg <= 16'h0000;
		else if (!active)
			cnt_reg <= 16'h0000;
		else if (cnt_reg < 16'(LIMIT))
			cnt_reg <= cnt_reg + 16'h0001;
	end

	assign qualified = active && (cnt_reg >= 16'(LIMIT));
endmodule

// ===== hdl/frs_sequencer.sv
// Reset sequencer: power-on, warm and software reset control
`timescale 1ns/10ps
module frs_sequencer #(
	parameter int POWER_UP_CYCLES = frs_pkg::POWER_UP_CYC,
	parameter int RECOVERY_CYCLES = frs_pkg::RECOVERY_CYC
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	// Pins from the host
	input  wire logic       select_n_pin,
	input  wire logic       restart_n_pin,
	input  wire logic       shared_line3_restart_pin,
	// Configuration bits
	input  wire logic       quad_enable_volatile,
	input  wire logic       qpi_enable_volatile,
	input  wire logic       line3_restart_enable_volatile,
	input  wire logic       line3_restart_enable_nv,
	// From the command engine
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_code,
	input  wire logic       quad_read_done,
	input  wire logic       power_up_ok,
	// Status and control outputs
	output logic            core_reset,
	output logic            regs_restore,
	output logic            outputs_tristate,
	output logic            cmd_reject,
	output logic            select_allowed,
	output logic            line3_drive_high,
	output logic            line3_drive_oe_n,
	output logic            reset_busy
);
	frs_pkg::frs_state_t state_reg;
	logic [frs_pkg::CNT_W-1:0] cnt_reg;
	logic [2:0] sel_sync_reg;
	logic [2:0] rst_sync_reg;
	logic [2:0] l3_sync_reg;
	logic       sel_n;
	logic       rst_n_s;
	logic       l3_n;
	logic [7:0] guard_reg;
	logic       guard_done;
	logic       l3_is_reset;
	logic       rst_low_any;
	logic       rst_qual;
	logic       soft_armed_reg;
	logic       soft_go;
	logic       por_failed_reg;
	logic       full_por_reg;
	logic       l3_hold_reg;
	logic       abort_reg;

	// Two-stage synchronisers; stage 0 feeds only stage 1
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sel_sync_reg <= 3'h7;
			rst_sync_reg <= 3'h7;
			l3_sync_reg  <= 3'h7;
		end
		else
		begin
			sel_sync_reg <= {sel_sync_reg[1:0], select_n_pin};
			rst_sync_reg <= {rst_sync_reg[1:0], restart_n_pin};
			l3_sync_reg  <= {l3_sync_reg[1:0], shared_line3_restart_pin};
		end
	end

	assign sel_n   = sel_sync_reg[1];
	assign rst_n_s = rst_sync_reg[1];
	assign l3_n    = l3_sync_reg[1];

	// Guard timer restarts on every select rise
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			guard_reg <= 8'h00;
		else if (!sel_n)
			guard_reg <= 8'h00;
		else if (guard_reg < 8'(frs_pkg::GUARD_CYC))
			guard_reg <= guard_reg + 8'h01;
	end

	assign guard_done = sel_n && (guard_reg >= 8'(frs_pkg::GUARD_CYC));

	// Shared pin is a reset input only when its enables allow
	assign l3_is_reset = line3_restart_enable_nv
		&& line3_restart_enable_volatile
		&& (guard_done || !quad_enable_volatile
		|| !qpi_enable_volatile);

	assign rst_low_any = !rst_n_s || (l3_is_reset && !l3_n);

	frs_low_timer #(
		.LIMIT (frs_pkg::PULSE_CYC)
	) u_low_timer (
		.sys_clk   (sys_clk),
		.arst_n    (arst_n),
		.active    (rst_low_any),
		.qualified (rst_qual)
	);

	// Software reset: arm then execute, accepted only in FRS_READY
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			soft_armed_reg <= 1'b0;
		else if (cmd_valid && state_reg == frs_pkg::FRS_READY)
			soft_armed_reg <= (cmd_code == frs_pkg::CMD_SOFT_ARM);
	end

	assign soft_go = cmd_valid && soft_armed_reg
		&& (cmd_code == frs_pkg::CMD_SOFT_EXEC)
		&& state_reg == frs_pkg::FRS_READY;

	// Power-on result latched at end of delay, caught after release
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			por_failed_reg <= 1'b0;
		else if (state_reg == frs_pkg::FRS_POWER_UP && cnt_reg == '0)
			por_failed_reg <= !power_up_ok;
		else if (full_por_reg)
			por_failed_reg <= 1'b0;
	end

	// Main sequence
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg    <= frs_pkg::FRS_POWER_UP;
			cnt_reg      <= frs_pkg::CNT_W'(POWER_UP_CYCLES);
			full_por_reg <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				frs_pkg::FRS_POWER_UP:
				begin
					// Reset pins ignored while counting down
					if (cnt_reg != '0)
						cnt_reg <= cnt_reg - 1'b1;
					else if (rst_low_any)
						state_reg <= frs_pkg::FRS_POWER_UP;
					else
					begin
						state_reg    <= frs_pkg::FRS_HOLD;
						cnt_reg      <= frs_pkg::CNT_W'(frs_pkg::HOLD_CYC);
						full_por_reg <= 1'b0;
					end
				end
				frs_pkg::FRS_READY:
				begin
					if (rst_qual && por_failed_reg)
					begin
						state_reg    <= frs_pkg::FRS_POWER_UP;
						cnt_reg      <= frs_pkg::CNT_W'(POWER_UP_CYCLES);
						full_por_reg <= 1'b1;
					end
					else if (rst_qual)
					begin
						state_reg <= frs_pkg::FRS_RECOVER;
						cnt_reg   <= frs_pkg::CNT_W'(RECOVERY_CYCLES);
					end
					else if (soft_go)
					begin
						state_reg <= frs_pkg::FRS_SOFT;
						cnt_reg   <= frs_pkg::CNT_W'(frs_pkg::SOFT_CYC);
					end
				end
				frs_pkg::FRS_SOFT:
				begin
					// Hardware reset ignored here
					if (cnt_reg != '0)
						cnt_reg <= cnt_reg - 1'b1;
					else
					begin
						state_reg <= frs_pkg::FRS_SETUP;
						cnt_reg   <= frs_pkg::CNT_W'(frs_pkg::SETUP_CYC);
					end
				end
				frs_pkg::FRS_RECOVER:
				begin
					if (cnt_reg != '0)
						cnt_reg <= cnt_reg - 1'b1;
					else if (!rst_low_any)
					begin
						state_reg <= frs_pkg::FRS_HOLD;
						cnt_reg   <= frs_pkg::CNT_W'(frs_pkg::HOLD_CYC);
					end
				end
				frs_pkg::FRS_HOLD:
				begin
					// Pin must stay high for the whole hold time
					if (rst_low_any)
						cnt_reg <= frs_pkg::CNT_W'(frs_pkg::HOLD_CYC);
					else if (cnt_reg != '0)
						cnt_reg <= cnt_reg - 1'b1;
					else
						state_reg <= frs_pkg::FRS_READY;
				end
				frs_pkg::FRS_SETUP:
				begin
					if (cnt_reg != '0)
						cnt_reg <= cnt_reg - 1'b1;
					else
						state_reg <= frs_pkg::FRS_READY;
				end
				default:
				begin
					state_reg <= frs_pkg::FRS_POWER_UP;
					cnt_reg   <= frs_pkg::CNT_W'(POWER_UP_CYCLES);
				end
			endcase
		end
	end

	// Abort pulse for running operations on warm reset entry
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			abort_reg <= 1'b0;
		else
			abort_reg <= (state_reg == frs_pkg::FRS_READY) && rst_qual;
	end

	// Drive line 3 high through guard after a quad read
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			l3_hold_reg <= 1'b0;
		else if (quad_read_done)
			l3_hold_reg <= 1'b1;
		else if (guard_done || !sel_n)
			l3_hold_reg <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			core_reset       <= 1'b1;
			regs_restore     <= 1'b0;
			outputs_tristate <= 1'b1;
			cmd_reject       <= 1'b1;
			select_allowed   <= 1'b0;
			reset_busy       <= 1'b1;
		end
		else
		begin
			core_reset   <= (state_reg != frs_pkg::FRS_READY);
			regs_restore <= abort_reg;
			// Outputs off only in power-up and recovery; commands refused until standby
			outputs_tristate <= (state_reg == frs_pkg::FRS_POWER_UP)
				|| (state_reg == frs_pkg::FRS_RECOVER);
			cmd_reject <= (state_reg != frs_pkg::FRS_READY);
			select_allowed <= (state_reg == frs_pkg::FRS_READY);
			reset_busy <= (state_reg != frs_pkg::FRS_READY);
		end
	end

	assign line3_drive_high = 1'b1;
	assign line3_drive_oe_n = !(l3_hold_reg && sel_n);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	// Dedicated pin high, so only the shared pin could have fired
	property p_guard_quiet;
		(state_reg == frs_pkg::FRS_READY && quad_enable_volatile
		&& qpi_enable_volatile && sel_n && !guard_done && rst_n_s)
		|=> state_reg != frs_pkg::FRS_RECOVER;
	endproperty
	a_guard_quiet: assert property (p_guard_quiet)
		else $error("reset taken during guard time");
	property p_recover_reject;
		state_reg == frs_pkg::FRS_RECOVER |=> cmd_reject;
	endproperty
	a_recover_reject: assert property (p_recover_reject)
		else $error("command accepted during recovery");
	property p_recover_tristate;
		state_reg == frs_pkg::FRS_RECOVER |=> outputs_tristate;
	endproperty
	a_recover_tristate: assert property (p_recover_tristate)
		else $error("outputs driven during recovery");
	property p_nv_off;
		!line3_restart_enable_nv |-> !l3_is_reset;
	endproperty
	a_nv_off: assert property (p_nv_off)
		else $error("shared pin reset while disabled");
	property p_soft_ign;
		state_reg == frs_pkg::FRS_SOFT |=>
		state_reg inside {frs_pkg::FRS_SOFT, frs_pkg::FRS_SETUP};
	endproperty
	a_soft_ign: assert property (p_soft_ign)
		else $error("soft reset interrupted");
	property p_power_up_hold;
		(state_reg == frs_pkg::FRS_POWER_UP && cnt_reg != '0)
		|=> state_reg == frs_pkg::FRS_POWER_UP;
	endproperty
	a_power_up_hold: assert property (p_power_up_hold)
		else $error("power-up left early");
	property p_ready_select;
		state_reg == frs_pkg::FRS_READY |=> select_allowed;
	endproperty
	a_ready_select: assert property (p_ready_select)
		else $error("select refused in standby");
	property p_read_hold;
		quad_read_done |=> l3_hold_reg;
	endproperty
	a_read_hold: assert property (p_read_hold)
		else $error("line 3 not held after quad read");
endmodule

// ===== verification/frs_host_model.sv
// Host controller model driving select and the two reset lines
`timescale 1ns/10ps
module frs_host_model (
	// Clock
	input  wire logic sys_clk,
	// Host pins
	output logic      select_n,
	output logic      restart_n,
	output logic      line3_oe,
	output logic      line3_val
);
	initial
	begin
		select_n  = 1'b1;
		restart_n = 1'b1;
		line3_oe  = 1'b0;
		line3_val = 1'b1;
	end

	// Select low for one command frame, then released
	task automatic frame(input int cyc);
		@(posedge sys_clk);
		select_n <= 1'b0;
		repeat (cyc) @(posedge sys_clk);
		select_n <= 1'b1;
	endtask

	// Low pulse on one line, optionally inside a selected command
	task automatic pulse(input bit shared, input bit sel, input int cyc);
		// Gap covers setup and the select-high guard
		repeat (8) @(posedge sys_clk);
		select_n  <= !sel;
		line3_oe  <= shared;
		line3_val <= 1'b0;
		restart_n <= shared;
		repeat (cyc) @(posedge sys_clk);
		select_n  <= 1'b1;
		line3_val <= 1'b1;
		restart_n <= 1'b1;
		@(posedge sys_clk);
		// Released line falls back to the pull-up
		line3_oe  <= 1'b0;
	endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/10ps
module tb;
	localparam int PU = 120;
	localparam int RC = 40;
	logic       sys_clk, arst_n, qe, four_wire_command_mode, en_v, en_nv, cv, qrd, pu_ok;
	logic [7:0] code;
	logic       sel_n, rst_n, h_oe, h_val, line3;
	logic       c_rst, restore, tri_o, rej, sel_ok, d_hi, d_oe_n, busy;
	int         n_fail, tests_run, n_rst, n;

	// Shared line: device drive, then host, else pull-up
	assign line3 = !d_oe_n ? d_hi : (h_oe ? h_val : 1'b1);

	frs_host_model frs_host_model_inst (.sys_clk(sys_clk),
		.select_n(sel_n), .restart_n(rst_n), .line3_oe(h_oe),
		.line3_val(h_val));

	frs_sequencer #(.POWER_UP_CYCLES(PU), .RECOVERY_CYCLES(RC))
	frs_sequencer_inst (.sys_clk(sys_clk), .arst_n(arst_n),
		.select_n_pin(sel_n), .restart_n_pin(rst_n),
		.shared_line3_restart_pin(line3), .quad_enable_volatile(qe),
		.qpi_enable_volatile(four_wire_command_mode), .line3_restart_enable_volatile(en_v),
		.line3_restart_enable_nv(en_nv), .cmd_valid(cv), .cmd_code(code),
		.quad_read_done(qrd), .power_up_ok(pu_ok), .core_reset(c_rst),
		.regs_restore(restore), .outputs_tristate(tri_o),
		.cmd_reject(rej), .select_allowed(sel_ok),
		.line3_drive_high(d_hi), .line3_drive_oe_n(d_oe_n),
		.reset_busy(busy));

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
		if (restore === 1'b1)
			n_rst <= n_rst + 1;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Cycles until the device accepts select again
	task automatic ready(output int c);
		c = 0;
		while (sel_ok !== 1'b1 && c < 1000)
		begin
			@(posedge sys_clk);
			#1;
			c++;
		end
		if (c >= 1000)
			n_fail++;
	endtask

	task automatic warm(input bit sh, input bit sel, input int cyc,
		input bit exp);
		int r0;
		r0 = n_rst;
		fork
			frs_host_model_inst.pulse(sh, sel, cyc);
			begin
				repeat (cyc + 6) @(posedge sys_clk);
				#1;
				check({c_rst, tri_o, rej}, {3{exp}});
			end
		join
		ready(n);
		check(n_rst - r0, exp);
		if (exp)
			check(n >= RC, 1);
	endtask

	task automatic restart_chip();
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
	endtask

	task automatic conclude();
		$display("checks=%0d fails=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		conclude();
	end

	initial
	begin
		{arst_n, qe, four_wire_command_mode, cv, qrd, code} = '0;
		{en_v, en_nv, pu_ok} = 3'b111;
		{n_fail, tests_run, n_rst} = '0;
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		fork
			frs_host_model_inst.pulse(0, 0, 60);
		join_none
		ready(n);
		check(n >= PU, 1);
		check(n_rst, 0);
		warm(0, 0, 10, 1'b0);
		warm(0, 0, 30, 1'b1);
		{qe, four_wire_command_mode} <= 2'b11;
		warm(1, 1, 30, 1'b0);
		warm(1, 0, 30, 1'b1);
		en_nv <= 1'b0;
		warm(1, 0, 30, 1'b0);
		{en_nv, en_v} <= 2'b10;
		warm(1, 0, 30, 1'b0);
		{en_v, qe} <= 2'b10;
		warm(1, 1, 30, 1'b1);
		qe <= 1'b1;
		frs_host_model_inst.frame(4);
		// Read ends as the synchronised select rises
		repeat (2) @(posedge sys_clk);
		qrd <= 1'b1;
		@(posedge sys_clk);
		qrd <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		check({d_oe_n, d_hi, line3}, 3'b011);
		repeat (12) @(posedge sys_clk);
		#1;
		check(d_oe_n, 1);
		@(posedge sys_clk);
		{cv, code} <= {1'b1, 8'h66};
		@(posedge sys_clk);
		code <= 8'h99;
		@(posedge sys_clk);
		cv <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		check(busy, 1);
		n = n_rst;
		frs_host_model_inst.pulse(0, 0, 30);
		check(n_rst, n);
		ready(n);
		pu_ok <= 1'b0;
		restart_chip();
		ready(n);
		pu_ok <= 1'b1;
		frs_host_model_inst.pulse(0, 0, 30);
		ready(n);
		check(n >= 100, 1);
		restart_chip();
		fork
			frs_host_model_inst.pulse(0, 0, PU + 40);
		join_none
		ready(n);
		check(n >= PU + 48, 1);
		conclude();
	end
endmodule
